// ### design/clhbp_pkg.sv
// Constants and types shared by the character display host port
package clhbp_pkg;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 7;
	localparam int BUSY_BIT = 7;
	localparam int HALVES = 2;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [7:0] INSTR_RST = 8'h00;
	// Register choose encoding
	localparam logic RSEL_INSTR = 1'b0;
	localparam logic RSEL_DATA = 1'b1;
	// Direction encoding
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	// Internal operation time after an instruction, in ns
	localparam int INSTR_BUSY_NS = 400;
	localparam int CLK_PERIOD_NS = 10;
	localparam int INSTR_BUSY_CYC = (INSTR_BUSY_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int BUSY_W = 8;

	typedef enum logic [1:0] {
		CLHBP_IDLE = 2'b00,
		CLHBP_ACTIVE = 2'b01,
		CLHBP_DONE = 2'b11
	} clhbp_phase_e;
endpackage

// ### design/clhbp_sync.sv
// Two-stage synchroniser for asynchronous host pins
`timescale 1ns/100ps
module clhbp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} clhbp_sync_s;

	clhbp_sync_s st_q;
	clhbp_sync_s st_d;

	always_comb begin
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule

// ### design/clhbp_port.sv
// Host bus port of the character display, with register file and RAM side
`timescale 1ns/100ps
module clhbp_port (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Configuration
	input wire logic nibble_mode,
	input wire logic dual_strobe,
	input wire logic addr_decrement,
	// Host pins
	input wire logic reg_choose,
	input wire logic read_sel,
	input wire logic enable_strobe,
	input wire logic upper_half_strobe,
	input wire logic lower_half_strobe,
	input wire logic [3:0] high_nibble_lines_in,
	input wire logic [3:0] low_nibble_lines_in,
	output logic [3:0] high_nibble_lines_out,
	output logic [3:0] low_nibble_lines_out,
	output logic high_nibble_lines_oe,
	output logic low_nibble_lines_oe,
	// Display RAM side
	output logic ram_wr,
	output logic ram_rd,
	output logic [6:0] ram_addr,
	output logic [7:0] ram_wdata,
	input wire logic [7:0] ram_rdata,
	output logic ram_half,
	// Instruction side
	output logic instr_valid,
	output logic [7:0] instr_code,
	input wire logic instr_sets_addr,
	input wire logic [6:0] instr_addr,
	// Status
	output logic busy_flag
);
	typedef struct packed {
		logic [1:0] strobe_prev;
		logic active_half;
		logic nib_second;
		logic [7:0] wr_byte;
		logic [7:0] instruction_reg;
		logic [7:0] data_reg;
		logic [6:0] address_counter;
		logic [7:0] busy_cnt;
		logic instr_valid;
		logic ram_wr;
		logic ram_rd;
		logic [7:0] ram_wdata;
		logic [6:0] ram_addr;
		logic fetch_pending;
		clhbp_pkg::clhbp_phase_e phase;
	} clhbp_port_s;

	clhbp_port_s st_q;
	clhbp_port_s st_d;
	logic [12:0] pins_raw;
	logic [12:0] pins_s;
	logic s_rsel;
	logic s_rd;
	logic [1:0] s_strobe;
	logic [3:0] s_hi;
	logic [3:0] s_lo;
	logic [1:0] fall;
	logic xfer_end;
	logic xfer_half;
	logic byte_done;
	logic [7:0] rd_byte;
	logic [7:0] cur_byte;

	function automatic logic [6:0] step_addr(input logic [6:0] a,
		input logic dec);
		step_addr = dec ? a - 7'h01 : a + 7'h01;
	endfunction

	assign pins_raw = {reg_choose, read_sel, enable_strobe, upper_half_strobe,
		lower_half_strobe, high_nibble_lines_in, low_nibble_lines_in};

	clhbp_sync #(.W(13)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	assign s_rsel = pins_s[12];
	assign s_rd = pins_s[11];
	assign s_hi = pins_s[7:4];
	assign s_lo = pins_s[3:0];
	// Single-strobe parts use the plain enable for the upper half
	assign s_strobe = dual_strobe ? {pins_s[9], pins_s[8]} :
		{pins_s[10], 1'b0};
	// Data is latched on the falling edge of the strobe
	assign fall = st_q.strobe_prev & ~s_strobe;
	assign xfer_end = |fall;
	// Upper strobe has priority should both fall together
	assign xfer_half = fall[1] ? 1'b0 : 1'b1;

	// Status read: busy on the top line, counter below
	assign rd_byte = (s_rsel == clhbp_pkg::RSEL_INSTR) ?
		{st_q.busy_cnt != '0, st_q.address_counter} : st_q.data_reg;
	// Second nibble of a 4-bit pair carries the low half
	assign cur_byte = {s_hi, nibble_mode ? st_q.wr_byte[3:0] : s_lo};
	assign byte_done = ~nibble_mode | st_q.nib_second;

	always_comb begin
		st_d = st_q;
		st_d.strobe_prev = s_strobe;
		st_d.instr_valid = 1'b0;
		st_d.ram_wr = 1'b0;
		st_d.ram_rd = 1'b0;
		if (st_q.busy_cnt != '0) begin
			st_d.busy_cnt = st_q.busy_cnt - 8'h01;
		end
		if (st_q.fetch_pending) begin
			// Fetch the byte at the current address into the data register
			st_d.data_reg = ram_rdata;
			st_d.fetch_pending = 1'b0;
		end
		st_d.phase = (s_strobe != 2'b00) ? clhbp_pkg::CLHBP_ACTIVE :
			clhbp_pkg::CLHBP_IDLE;
		if (xfer_end) begin
			st_d.phase = clhbp_pkg::CLHBP_DONE;
			st_d.active_half = xfer_half;
			if (nibble_mode && !st_q.nib_second) begin
				// First nibble is the high half
				st_d.wr_byte = {4'h0, s_hi};
				st_d.nib_second = 1'b1;
			end else begin
				st_d.nib_second = 1'b0;
			end
			if (byte_done) begin
				case ({s_rsel, s_rd})
				{clhbp_pkg::RSEL_INSTR, clhbp_pkg::DIR_WRITE}: begin
					// Instruction write
					st_d.instruction_reg = nibble_mode ?
						{st_q.wr_byte[3:0], s_hi} : cur_byte;
					st_d.instr_valid = 1'b1;
					st_d.busy_cnt = 8'(clhbp_pkg::INSTR_BUSY_CYC);
					if (instr_sets_addr) begin
						st_d.address_counter = instr_addr;
						st_d.ram_addr = instr_addr;
						st_d.ram_rd = 1'b1;
						st_d.fetch_pending = 1'b1;
					end
				end
				{clhbp_pkg::RSEL_DATA, clhbp_pkg::DIR_WRITE}: begin
					// Data write forwarded to RAM at once
					st_d.data_reg = nibble_mode ?
						{st_q.wr_byte[3:0], s_hi} : cur_byte;
					st_d.ram_wdata = st_d.data_reg;
					st_d.ram_addr = st_q.address_counter;
					st_d.ram_wr = 1'b1;
					st_d.address_counter =
						step_addr(st_q.address_counter, addr_decrement);
				end
				{clhbp_pkg::RSEL_DATA, clhbp_pkg::DIR_READ}: begin
					// Advance and prefetch the next byte
					st_d.address_counter =
						step_addr(st_q.address_counter, addr_decrement);
					st_d.ram_addr = st_d.address_counter;
					st_d.ram_rd = 1'b1;
					st_d.fetch_pending = 1'b1;
				end
				default: begin
				end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '{strobe_prev: 2'b00, active_half: 1'b0,
				nib_second: 1'b0, wr_byte: clhbp_pkg::DATA_RST,
				instruction_reg: clhbp_pkg::INSTR_RST,
				data_reg: clhbp_pkg::DATA_RST,
				address_counter: clhbp_pkg::ADDR_RST, busy_cnt: 8'h00,
				instr_valid: 1'b0, ram_wr: 1'b0, ram_rd: 1'b0,
				ram_wdata: clhbp_pkg::DATA_RST,
				ram_addr: clhbp_pkg::ADDR_RST, fetch_pending: 1'b0,
				phase: clhbp_pkg::CLHBP_IDLE};
		end else begin
			st_q <= st_d;
		end
	end

	// Drive only inside a synced read strobe; direction settles first
	assign high_nibble_lines_oe = s_rd & (s_strobe != 2'b00);
	assign low_nibble_lines_oe = s_rd & (s_strobe != 2'b00) &
		~nibble_mode;
	assign high_nibble_lines_out = (nibble_mode && st_q.nib_second) ?
		rd_byte[3:0] : rd_byte[7:4];
	assign low_nibble_lines_out = nibble_mode ? 4'h0 : rd_byte[3:0];
	assign busy_flag = st_q.busy_cnt != '0;
	assign ram_wr = st_q.ram_wr;
	assign ram_rd = st_q.ram_rd;
	assign ram_addr = st_q.ram_addr;
	assign ram_wdata = st_q.ram_wdata;
	assign ram_half = st_q.active_half;
	assign instr_valid = st_q.instr_valid;
	assign instr_code = st_q.instruction_reg;
endmodule

// ### testbench/clhbp_port_asserts.sv
// Assertions on the display host port pins
`timescale 1ns/100ps
module clhbp_port_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic nibble_mode,
	input wire logic reg_choose,
	input wire logic [3:0] high_nibble_lines_out,
	input wire logic high_nibble_lines_oe,
	input wire logic low_nibble_lines_oe,
	input wire logic ram_wr,
	input wire logic ram_rd,
	input wire logic instr_valid,
	input wire logic busy_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_lo_off; nibble_mode |-> !low_nibble_lines_oe; endproperty
	a_lo_off: assert property (p_lo_off) else $error("low oe");
	property p_oe_pair;
		!nibble_mode |-> high_nibble_lines_oe == low_nibble_lines_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("oe split");
	property p_wr_quiet; ram_wr |-> !high_nibble_lines_oe; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("oe write");
	property p_busy_top;
		high_nibble_lines_oe && !reg_choose && !nibble_mode
			|-> high_nibble_lines_out[3] == busy_flag;
	endproperty
	a_busy_top: assert property (p_busy_top) else $error("busy line");
	property p_busy_hold; $rose(busy_flag) |-> busy_flag[*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy");
	property p_instr_busy; instr_valid |-> ##[0:1] busy_flag; endproperty
	a_instr_busy: assert property (p_instr_busy) else $error("no busy");
	property p_wr_pulse; ram_wr |=> !ram_wr; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("wr long");
	property p_rd_pulse; ram_rd |=> !ram_rd && !ram_wr; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("rd long");
endmodule
bind clhbp_port clhbp_port_asserts clhbp_port_asserts_inst (.*);

// ### testbench/clhbp_host_model.sv
// Host processor model driving the display port pins
`timescale 1ns/100ps
module clhbp_host_model (
	// Clock and mode
	input wire logic ref_clk,
	input wire logic nib,
	// Host pins
	output logic rs,
	output logic rd,
	output logic [2:0] stb,
	output logic [7:0] dq,
	// Resolved device drive
	input wire logic [7:0] dev_q
);
	logic [7:0] last;
	initial begin
		rs = 1'b0;
		rd = 1'b0;
		stb = 3'h0;
		dq = 8'hff;
	end
	task automatic xfer(input logic s, r, input logic [7:0] d,
		input logic [2:0] w, output logic [7:0] q);
		for (int i = 0; i < (nib ? 2 : 1); i++) begin
			@(posedge ref_clk) #1;
			rs = s;
			rd = r;
			last = (nib && i == 1) ? {d[3:0], 4'h0} : d;
			// Low lines grounded in 4-bit writes
			dq = r ? ~dq : (nib ? {last[7:4], 4'h0} : last);
			@(posedge ref_clk) #1;
			stb = w;
			repeat (4) @(posedge ref_clk);
			// Taken off the edge, while the strobe still stands
			#1 q = nib ? {q[3:0], dev_q[7:4]} : dev_q;
			stb = 3'h0;
			repeat (6) @(posedge ref_clk);
			// Released lines must not keep the old value
			#1 dq = ~dq;
		end
	endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the display host port
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
$display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
	logic ref_clk, sys_rst, nib, dual, rs, rd, hoe, loe, wr, rdp, half, busy;
	logic [2:0] stb;
	logic [3:0] ho, lo;
	logic [6:0] ra, wa;
	logic [7:0] dq, wd, wdv, q, ic, ics;
	logic iv;
	logic [7:0] mem [128];
	int compares = 0;
	int n_mismatch = 0;
	wire [7:0] bus = {hoe ? ho : dq[7:4], loe ? lo : dq[3:0]};
	clhbp_port clhbp_port_inst (.ref_clk, .sys_rst, .nibble_mode(nib),
		.dual_strobe(dual), .addr_decrement(1'b0), .reg_choose(rs),
		.read_sel(rd), .enable_strobe(stb[0]), .upper_half_strobe(stb[1]),
		.lower_half_strobe(stb[2]), .high_nibble_lines_in(bus[7:4]),
		.low_nibble_lines_in(bus[3:0]), .high_nibble_lines_out(ho),
		.low_nibble_lines_out(lo), .high_nibble_lines_oe(hoe),
		.low_nibble_lines_oe(loe), .ram_wr(wr), .ram_rd(rdp), .ram_addr(ra),
		.ram_wdata(wdv), .ram_rdata(mem[ra]), .ram_half(half),
		.instr_valid(iv), .instr_code(ic), .instr_sets_addr(bus[7]),
		.instr_addr(bus[6:0]), .busy_flag(busy));
	clhbp_host_model clhbp_host_model_inst (.ref_clk, .nib, .rs, .rd, .stb,
		.dq, .dev_q(bus));
	initial foreach (mem[i]) mem[i] = 8'h00;
	always @(posedge ref_clk) if (wr) begin
		mem[ra] <= wdv;
		wa <= ra;
		wd <= wdv;
	end
	always @(posedge ref_clk) if (iv) ics <= ic;
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic x(input logic s, r, input logic [7:0] d,
		input logic [2:0] w = 3'b001);
		clhbp_host_model_inst.xfer(s, r, d, w, q);
	endtask
	task automatic idle();
		for (int i = 0; i < 9; i++) begin
			x(0, 1, 8'h00);
			if (q[7] === 1'b0)
				return;
		end
		`CHK(q[7], 1'b0)
		end_sim();
	endtask
	task automatic t_status();
		x(0, 0, 8'h85);
		`CHK(ics, 8'h85)
		x(0, 1, 8'h00);
		`CHK(q, 8'h85)
		idle();
		`CHK(q, 8'h05)
		$display("t_status done");
	endtask
	task automatic t_data();
		x(1, 0, 8'ha5);
		`CHK({wa, wd}, {7'h05, 8'ha5})
		x(1, 0, 8'h3c);
		`CHK({wa, wd}, {7'h06, 8'h3c})
		x(0, 0, 8'h85);
		idle();
		x(1, 1, 8'h00);
		`CHK(q, 8'ha5)
		x(1, 1, 8'h00);
		`CHK(q, 8'h3c)
		$display("t_data done");
	endtask
	task automatic t_nib();
		nib = 1'b1;
		x(1, 0, 8'h96);
		`CHK({wa, wd}, {7'h07, 8'h96})
		// Address set in 8-bit mode, then read back as two nibbles
		nib = 1'b0;
		x(0, 0, 8'h87);
		idle();
		nib = 1'b1;
		x(1, 1, 8'h00);
		`CHK(q, 8'h96)
		nib = 1'b0;
		$display("t_nib done");
	endtask
	task automatic t_dual();
		dual = 1'b1;
		x(1, 0, 8'h11, 3'b100);
		`CHK(half, 1'b1)
		x(1, 0, 8'h22, 3'b010);
		`CHK(half, 1'b0)
		dual = 1'b0;
		$display("t_dual done");
	endtask
	task automatic t_reset();
		x(0, 0, 8'h85);
		`CHK(busy, 1'b1)
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(busy, 1'b0)
		x(0, 1, 8'h00);
		`CHK(q, 8'h00)
		$display("t_reset done");
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		sys_rst = 1'b1;
		nib = 1'b0;
		dual = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		// Synchroniser flush before the first strobe
		repeat (3) @(posedge ref_clk);
		t_status();
		t_data();
		t_nib();
		t_dual();
		t_reset();
		end_sim();
	end
endmodule
